//--- ledpwm_cfg.svh
// Register offsets, reset values, bit positions and timing counts for the LED PWM output block.
// Assumes a 40 MHz system clock; included by bare name wherever the constants are needed.
`ifndef LEDPWM_CFG_SVH
`define LEDPWM_CFG_SVH

`define OFS_PHASE0      8'h01
`define OFS_PHASE1      8'h09
`define OFS_INTENS      8'h0e
`define OFS_CONFIG      8'h0f
`define OFS_PORT_INT0   8'h10
`define OFS_PORT_INT3   8'h13

`define RST_PHASE       8'hff
`define RST_INTENS      8'h0f
`define RST_CONFIG      8'h34
`define RST_PORT_INT    8'hff

`define CFG_BLINK_EN    0
`define CFG_FLIP        1
`define CFG_GLOBAL      2
`define CFG_NINTH_P0    4
`define CFG_NINTH_P1    5
`define CFG_PIN_STAT    6
`define CFG_WR_MASK     8'h37

`define NIB_STATIC      4'hf
`define NIB_ZERO        4'h0
`define CYC_LAST        4'hf
`define SLOT_LAST       4'he

`define CLK_HZ          40000000
`define OSC_HZ          32000
`define OSC_DIV_LAST    11'(`CLK_HZ / `OSC_HZ - 1)
`define OSC_DIV_ZERO    11'h000

`endif

//--- ledpwm_pkg.sv
// Shared types of the LED PWM output block.
// Assumes nothing of its surroundings.
package ledpwm_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] nib_t;
  typedef logic [8:0] ports_t;
endpackage

//--- pwm_timebase.sv
// PWM timebase: internal oscillator divider, 16-cycle step counter and 15-slot counter.
// Assumes a reset already synchronised to clock; run low stops and clears everything.
`timescale 1ns/10ps
`default_nettype none
`include "ledpwm_cfg.svh"

module pwm_timebase
  import ledpwm_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            rst_n,
  input  wire logic            run,
  output logic                 tick,
  output ledpwm_pkg::nib_t     cycle,
  output ledpwm_pkg::nib_t     slot
);
  import ledpwm_pkg::*;

  logic [10:0] div_r;
  logic [10:0] div_nxt;
  nib_t        cyc_r;
  nib_t        cyc_nxt;
  nib_t        slot_r;
  nib_t        slot_nxt;

  // Roughly 32 kHz tick taken from the system clock
  assign tick  = run && (div_r == `OSC_DIV_LAST);
  assign cycle = cyc_r;
  assign slot  = slot_r;

  always_comb begin
    div_nxt  = div_r;
    cyc_nxt  = cyc_r;
    slot_nxt = slot_r;
    if (!run) begin
      // Oscillator stopped: saves power, and PWM restarts at slot 0 when enabled
      div_nxt  = `OSC_DIV_ZERO;
      cyc_nxt  = `NIB_ZERO;
      slot_nxt = `NIB_ZERO;
    end else if (tick) begin
      div_nxt = `OSC_DIV_ZERO;
      cyc_nxt = cyc_r + 4'h1;
      if (cyc_r == `CYC_LAST) begin
        slot_nxt = (slot_r == `SLOT_LAST) ? `NIB_ZERO : slot_r + 4'h1;
      end
    end else begin
      div_nxt = div_r + 11'h001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r  <= `OSC_DIV_ZERO;
      cyc_r  <= `NIB_ZERO;
      slot_r <= `NIB_ZERO;
    end else begin
      div_r  <= div_nxt;
      cyc_r  <= cyc_nxt;
      slot_r <= slot_nxt;
    end
  end
endmodule
`default_nettype wire

//--- led_blink_phase_pwm_output_ctrl.sv
// Blink phase selection, register file and PWM shaping for nine open-drain LED ports.
// Assumes a decoded register port (byte address, write and read strobes) and a phase pin synchronous to clock.
`timescale 1ns/10ps
`default_nettype none
`include "ledpwm_cfg.svh"

module led_blink_phase_pwm_output_ctrl
  import ledpwm_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                blink_pin,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  input  wire ledpwm_pkg::byte_t   reg_addr,
  input  wire ledpwm_pkg::byte_t   reg_wdata,
  output ledpwm_pkg::byte_t        reg_rdata,
  output ledpwm_pkg::ports_t       port_out,
  output ledpwm_pkg::ports_t       port_oe
);
  import ledpwm_pkg::*;

  logic   rst_meta_r;
  logic   rst_sync_n;
  byte_t  phase0_port_levels_r;
  byte_t  phase0_port_levels_nxt;
  byte_t  phase1_port_levels_r;
  byte_t  phase1_port_levels_nxt;
  byte_t  intensity_r;
  byte_t  intensity_nxt;
  byte_t  device_configuration_r;
  byte_t  device_configuration_nxt;
  byte_t  port_int_r [4];
  byte_t  port_int_nxt [4];
  byte_t  rdata_r;
  byte_t  rdata_nxt;
  ports_t oe_r;
  ports_t oe_nxt;
  ports_t out_r;
  ports_t level;
  nib_t   duty [9];
  logic   blink_en;
  logic   phase1;
  logic   pwm_on;
  logic   tick;
  nib_t   cycle;
  nib_t   slot;
  nib_t   master;

  // Reset released through two flops so every register leaves reset on the same edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // Port drive: selected level with PWM off, at static duty or in the on-part of a gated slot, opposite otherwise
  function automatic logic drive_level(logic lvl, nib_t dty, logic on, nib_t slt, nib_t cyc, nib_t mst);
    logic res;
    res = lvl;
    if (on && (dty != `NIB_STATIC)) begin
      if ((slt < mst) && (cyc <= dty)) begin
        res = lvl;
      end else begin
        res = ~lvl;
      end
    end
    return res;
  endfunction

  assign blink_en = device_configuration_r[`CFG_BLINK_EN];
  assign phase1   = blink_en && (device_configuration_r[`CFG_FLIP] ^ blink_pin);
  assign master   = intensity_r[7:4];
  assign pwm_on   = (master != `NIB_ZERO);

  always_comb begin
    level[7:0] = phase1 ? phase1_port_levels_r : phase0_port_levels_r;
    level[8]   = phase1 ? device_configuration_r[`CFG_NINTH_P1] : device_configuration_r[`CFG_NINTH_P0];
  end

  pwm_timebase pwm_timebase_i (
    .clock (clock),
    .rst_n (rst_sync_n),
    .run   (pwm_on),
    .tick  (tick),
    .cycle (cycle),
    .slot  (slot)
  );

  for (genvar i = 0; i < 9; i++) begin : g_port
    if (i == 8) begin : g_ninth
      assign duty[i] = intensity_r[3:0];
    end else begin : g_main
      // Global select overrides the per-port nibbles entirely
      assign duty[i] = device_configuration_r[`CFG_GLOBAL] ? intensity_r[3:0]
                     : port_int_r[i/2][4*(i%2) +: 4];
    end
    // Level 1 releases the pin, level 0 pulls it low; duty range follows from the level
    assign oe_nxt[i] = ~drive_level(level[i], duty[i], pwm_on, slot, cycle, master);
  end

  always_comb begin
    phase0_port_levels_nxt   = phase0_port_levels_r;
    phase1_port_levels_nxt   = phase1_port_levels_r;
    intensity_nxt            = intensity_r;
    device_configuration_nxt = device_configuration_r;
    for (int k = 0; k < 4; k++) begin
      port_int_nxt[k] = port_int_r[k];
    end
    rdata_nxt = rdata_r;
    if (reg_write) begin
      unique case (reg_addr)
        `OFS_PHASE0: phase0_port_levels_nxt = reg_wdata;
        `OFS_PHASE1: phase1_port_levels_nxt = reg_wdata;
        `OFS_INTENS: intensity_nxt = reg_wdata;
        `OFS_CONFIG: device_configuration_nxt = reg_wdata & `CFG_WR_MASK;
        default: begin
          if ((reg_addr >= `OFS_PORT_INT0) && (reg_addr <= `OFS_PORT_INT3)) begin
            port_int_nxt[reg_addr[1:0]] = reg_wdata;
          end
        end
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        `OFS_PHASE0: rdata_nxt = phase0_port_levels_r;
        `OFS_PHASE1: rdata_nxt = phase1_port_levels_r;
        `OFS_INTENS: rdata_nxt = intensity_r;
        `OFS_CONFIG: begin
          rdata_nxt = device_configuration_r;
          rdata_nxt[`CFG_PIN_STAT] = blink_pin;
        end
        default: begin
          if ((reg_addr >= `OFS_PORT_INT0) && (reg_addr <= `OFS_PORT_INT3)) begin
            rdata_nxt = port_int_r[reg_addr[1:0]];
          end else begin
            rdata_nxt = 8'h00;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase0_port_levels_r   <= `RST_PHASE;
      phase1_port_levels_r   <= `RST_PHASE;
      intensity_r            <= `RST_INTENS;
      device_configuration_r <= `RST_CONFIG;
      for (int k = 0; k < 4; k++) begin
        port_int_r[k] <= `RST_PORT_INT;
      end
      rdata_r <= 8'h00;
      oe_r    <= 9'h000;
      out_r   <= 9'h000;
    end else begin
      phase0_port_levels_r   <= phase0_port_levels_nxt;
      phase1_port_levels_r   <= phase1_port_levels_nxt;
      intensity_r            <= intensity_nxt;
      device_configuration_r <= device_configuration_nxt;
      for (int k = 0; k < 4; k++) begin
        port_int_r[k] <= port_int_nxt[k];
      end
      rdata_r <= rdata_nxt;
      oe_r    <= oe_nxt;
      // Open drain: the pin level when driven is always low
      out_r   <= 9'h000;
    end
  end

  assign reg_rdata = rdata_r;
  assign port_out  = out_r;
  assign port_oe   = oe_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  sequence s_static_blink_off;
    !pwm_on && !blink_en;
  endsequence

  sequence s_static_phase1;
    !pwm_on && blink_en && (device_configuration_r[`CFG_FLIP] ^ blink_pin);
  endsequence

  sequence s_last_step;
    tick && (cycle == `CYC_LAST) && (slot == `SLOT_LAST);
  endsequence

  a_blink_off_phase0: assert property (s_static_blink_off |=> port_oe[7:0] == ~$past(phase0_port_levels_r))
    else $error("blink off: ports not from phase 0 register");
  a_blink_on_phase1: assert property (s_static_phase1 |=> port_oe[7:0] == ~$past(phase1_port_levels_r))
    else $error("phase 1: ports not from phase 1 register");
  a_phase_xor_sel: assert property ((!pwm_on && blink_en && !(device_configuration_r[`CFG_FLIP] ^ blink_pin))
    |=> port_oe[7:0] == ~$past(phase0_port_levels_r))
    else $error("phase 0 not selected when flag xor pin is 0");
  a_read_stored: assert property ((reg_read && reg_addr == `OFS_PHASE0) |=> reg_rdata == $past(phase0_port_levels_r))
    else $error("phase 0 readback not the stored value");
  a_ninth_phase0: assert property ((!pwm_on && !phase1) |=> port_oe[8] == !$past(device_configuration_r[`CFG_NINTH_P0]))
    else $error("ninth port not from D4");
  a_ninth_phase1: assert property (s_static_phase1 |=> port_oe[8] == !$past(device_configuration_r[`CFG_NINTH_P1]))
    else $error("ninth port not from D5");
  a_pin_status: assert property ((reg_read && reg_addr == `OFS_CONFIG) |=> reg_rdata[`CFG_PIN_STAT] == $past(blink_pin))
    else $error("config D6 not the phase pin level");
  a_period_wrap: assert property (s_last_step |=> (cycle == `NIB_ZERO) && (slot == `NIB_ZERO))
    else $error("period does not wrap after slot 15 cycle 16");
  a_slot_advance: assert property ((tick && (cycle == `CYC_LAST) && (slot != `SLOT_LAST))
    |=> slot == $past(slot) + 4'h1)
    else $error("slot does not advance after 16 cycles");
  a_osc_stopped: assert property (!pwm_on |=> !tick && (cycle == `NIB_ZERO) && (slot == `NIB_ZERO))
    else $error("oscillator runs with master at zero");
  a_static_full: assert property ((pwm_on && duty[1] == `NIB_STATIC) |=> port_oe[1] == !$past(level[1]))
    else $error("full intensity port not static");
  a_gate_off: assert property ((pwm_on && duty[0] != `NIB_STATIC && slot >= master) |=> port_oe[0] == $past(level[0]))
    else $error("ungated slot does not show the opposite level");
  a_duty_on: assert property ((pwm_on && duty[1] != `NIB_STATIC && slot < master && cycle <= duty[1])
    |=> port_oe[1] == !$past(level[1]))
    else $error("on part of gated slot does not show the level");
endmodule
`default_nettype wire

//--- led_load_model.sv
// Pull-up loads on the nine open-drain LED ports, giving the level seen at each pin.
// Assumes port_oe high means the port sinks current and port_out is the driven value.
`timescale 1ns/10ps
`default_nettype none

module led_load_model
  import ledpwm_pkg::*;
(
  input  wire ledpwm_pkg::ports_t  port_out,
  input  wire ledpwm_pkg::ports_t  port_oe,
  output ledpwm_pkg::ports_t       pins
);
  import ledpwm_pkg::*;
  // A released port floats to the pull-up, never to the last driven value
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      pins[i] = port_oe[i] ? port_out[i] : 1'b1;
    end
  end
endmodule

`default_nettype wire

//--- led_blink_phase_pwm_output_ctrl_tb.sv
// Self-checking bench for the LED PWM output block, register port tasks and pin checks.
// Assumes the design package, the config header and the pull-up load model.
`timescale 1ns/10ps
`default_nettype none
`include "ledpwm_cfg.svh"

`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end

module led_blink_phase_pwm_output_ctrl_tb;
  import ledpwm_pkg::*;
  logic     clock = 1'b0;
  logic     rst_n = 1'b0;
  logic     blink_pin = 1'b0;
  logic     reg_write = 1'b0;
  logic     reg_read = 1'b0;
  byte_t    reg_addr = 8'h00;
  byte_t    reg_wdata = 8'h00;
  byte_t    reg_rdata;
  ports_t   port_out;
  ports_t   port_oe;
  ports_t   pins;
  byte_t    rv;
  int       err_total = 0;
  int       n_tests = 0;
  int       f0;
  int       f2;
  logic     ph;

  always #12.5 clock = ~clock;

  led_blink_phase_pwm_output_ctrl led_blink_phase_pwm_output_ctrl_i (
    .clock(clock), .rst_n(rst_n), .blink_pin(blink_pin), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .port_out(port_out), .port_oe(port_oe));
  led_load_model led_load_model_i (.port_out(port_out), .port_oe(port_oe), .pins(pins));

  task automatic wr(input byte_t a, input byte_t d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input byte_t a, output byte_t d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    #1 d = reg_rdata;
  endtask

  // Ports follow a register write on the edge after it lands
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic test_done();
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(`OFS_PHASE0, rv); `CHK(rv, 8'hff)
    rd(`OFS_INTENS, rv); `CHK(rv, 8'h0f)
    rd(`OFS_CONFIG, rv); `CHK(rv, 8'h34)
    rd(8'h03, rv); `CHK(rv, 8'h00)
    `CHK(port_oe, 9'h000)
    `CHK(port_out, 9'h000)
    $display("test reset done");
    wr(`OFS_PHASE0, 8'h5a);
    wr(`OFS_PHASE1, 8'h3c);
    rd(`OFS_PHASE0, rv); `CHK(rv, 8'h5a)
    settle(2); `CHK(pins[7:0], 8'h5a)
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_CONFIG, k[1] ? 8'h13 : 8'h11);
      blink_pin <= k[0];
      ph = k[1] ^ k[0];
      settle(3);
      `CHK(pins[7:0], ph ? 8'h3c : 8'h5a)
      `CHK(pins[8], ~ph)
    end
    wr(`OFS_CONFIG, 8'h02);
    blink_pin <= 1'b1;
    settle(3); `CHK(pins, 9'h05a)
    $display("test blink done");
    wr(`OFS_CONFIG, 8'hff);
    rd(`OFS_CONFIG, rv); `CHK(rv, 8'h77)
    blink_pin <= 1'b0;
    rd(`OFS_CONFIG, rv); `CHK(rv, 8'h37)
    $display("test config done");
    wr(`OFS_CONFIG, 8'h00);
    wr(`OFS_PHASE0, 8'hfe);
    wr(`OFS_PORT_INT0, 8'hf0);
    wr(8'h11, 8'h01);
    settle(2); `CHK(port_oe, 9'h101)
    wr(`OFS_INTENS, 8'h1f);
    f0 = 0;
    f2 = 0;
    for (int t = 1; t < 3000; t++) begin
      settle(1);
      if (f0 == 0 && port_oe[0] === 1'b0) f0 = t;
      if (f2 == 0 && port_oe[2] === 1'b1) f2 = t;
    end
    `CHK(f0 inside {[1248:1254]}, 1'b1)
    `CHK(f2 inside {[2498:2504]}, 1'b1)
    `CHK(port_oe[1], 1'b0)
    `CHK(port_oe[3], 1'b1)
    settle(17625); `CHK(port_oe[0], 1'b0)
    `CHK(port_oe[1], 1'b0)
    wr(`OFS_INTENS, 8'h00);
    wr(`OFS_INTENS, 8'h2f);
    settle(20625); `CHK(port_oe[0], 1'b1)
    $display("test pwm done");
    wr(`OFS_CONFIG, 8'h04);
    wr(`OFS_INTENS, 8'h00);
    wr(`OFS_INTENS, 8'h10);
    settle(625); `CHK(port_oe, 9'h101)
    settle(1250); `CHK(port_oe, 9'h0fe)
    $display("test global done");
    test_done();
  end
endmodule

`default_nettype wire
